// ### stpio_pin_drv.sv
// Status pin source select, polarity and drive mode
`default_nettype none
module stpio_pin_drv
  import stpio_pkg::*;
(
  input  wire logic SYS_CLK,
  input  wire logic SYS_RST,
  stpio_pin_if.pin  pif
);
  logic sig;
  logic val;
  logic nxt_o;
  logic nxt_oe;
  logic pin_o_ff;
  logic pin_oe_ff;
  logic pin_pu_ff;
  logic pin_pd_ff;
  logic [1:0] pin_str_ff;
  logic readback_ff;

  // ==========================================================
  // Source select
  always_comb begin
    unique case (pif.sel)
      STPIO_SEL_PLL_LOCK:  sig = pif.src[0];
      STPIO_SEL_REF0_LOS:  sig = pif.src[1];
      STPIO_SEL_XTAL_LOS:  sig = pif.src[2];
      STPIO_SEL_REF0_ACT:  sig = pif.src[3];
      STPIO_SEL_REF0_INV:  sig = pif.src[4];
      STPIO_SEL_DEV_INT:   sig = pif.src[5];
      STPIO_SEL_DEV_READY: sig = pif.src[6];
      STPIO_SEL_HIGH:      sig = 1'b1;
      default:             sig = 1'b0;
    endcase
  end

  // ==========================================================
  // Polarity and drive mode
  always_comb begin
    val = (pif.sel == STPIO_SEL_NOPOL) ? sig : (sig ^ pif.pol);
    if (pif.hiz) begin
      nxt_o  = 1'b0;
      nxt_oe = 1'b0;
    end else if (pif.od_en) begin
      nxt_o  = 1'b0;
      nxt_oe = ~val;
    end else begin
      nxt_o  = val;
      nxt_oe = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_o_ff    <= 1'b0;
      pin_oe_ff   <= 1'b0;
      pin_pu_ff   <= 1'b1;
      pin_pd_ff   <= 1'b0;
      pin_str_ff  <= 2'h0;
      readback_ff <= 1'b0;
    end else begin
      pin_o_ff    <= nxt_o;
      pin_oe_ff   <= nxt_oe;
      pin_pu_ff   <= pif.pu_en;
      pin_pd_ff   <= pif.pd_en;
      pin_str_ff  <= pif.od_en ? pif.od_str : pif.pp_str;
      readback_ff <= (pif.sel <= STPIO_SEL_RB_MAX) ? val : 1'b0;
    end
  end

  assign pif.pin_o    = pin_o_ff;
  assign pif.pin_oe   = pin_oe_ff;
  assign pif.pin_pu   = pin_pu_ff;
  assign pif.pin_pd   = pin_pd_ff;
  assign pif.pin_str  = pin_str_ff;
  assign pif.readback = readback_ff;

  // ==========================================================
  // Checks
  property p_hiz_floats;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      pif.hiz |=> !pin_oe_ff;
  endproperty
  a_hiz_floats: assert property (p_hiz_floats) else $error("tristate not floating");

  property p_od_drive;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (pif.od_en && !pif.hiz) |=> (!pin_o_ff && (pin_oe_ff == !$past(val)));
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open drain drive wrong");

  property p_const_low;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (pif.sel == STPIO_SEL_LOW && !pif.pol && !pif.hiz && !pif.od_en) |=>
        (pin_oe_ff && !pin_o_ff);
  endproperty
  a_const_low: assert property (p_const_low) else $error("constant low wrong");

  property p_nopol;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (pif.sel == STPIO_SEL_NOPOL && !pif.hiz && !pif.od_en) |=> !pin_o_ff;
  endproperty
  a_nopol: assert property (p_nopol) else $error("polarity not ignored");

  property p_rb_zero;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (pif.sel > STPIO_SEL_RB_MAX) |=> !readback_ff;
  endproperty
  a_rb_zero: assert property (p_rb_zero) else $error("readback not zero");

  property p_lock_pol;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (pif.sel == STPIO_SEL_PLL_LOCK && !pif.hiz && !pif.od_en) |=>
        (pin_o_ff == ($past(pif.src[0]) ^ $past(pif.pol)));
  endproperty
  a_lock_pol: assert property (p_lock_pol) else $error("lock polarity wrong");
endmodule
`default_nettype wire

// ### stpio_pin_if.sv
// Signals between the register block and the status pin driver
`default_nettype none
interface stpio_pin_if;
  logic [4:0] sel;
  logic       pol;
  logic       od_en;
  logic       hiz;
  logic       pd_en;
  logic       pu_en;
  logic [1:0] pp_str;
  logic [1:0] od_str;
  logic [6:0] src;
  logic       pin_o;
  logic       pin_oe;
  logic       pin_pu;
  logic       pin_pd;
  logic [1:0] pin_str;
  logic       readback;
  modport ctrl (
    output sel, pol, od_en, hiz, pd_en, pu_en, pp_str, od_str, src,
    input  pin_o, pin_oe, pin_pu, pin_pd, pin_str, readback
  );
  modport pin (
    input  sel, pol, od_en, hiz, pd_en, pu_en, pp_str, od_str, src,
    output pin_o, pin_oe, pin_pu, pin_pd, pin_str, readback
  );
endinterface
`default_nettype wire

// ### stpio_pin_mon.sv
// Board-side monitor that resolves the status pin wire level
`default_nettype none
module stpio_pin_mon #(
  parameter bit EXT_PULLUP = 1'b0
) (
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic pin_pu,
  input  wire logic pin_pd,
  output logic      level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_ff = 1'b0;
  // ==========================================================
  // Undriven wire wanders every cycle
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  // ==========================================================
  // Wire level from driver, pull resistors and board pull-up
  always_comb begin
    if (pin_oe) begin
      level = pin_o;
    end else if (pin_pu || EXT_PULLUP) begin
      level = 1'b1;
    end else if (pin_pd) begin
      level = 1'b0;
    end else begin
      level = float_ff;
    end
  end
endmodule
`default_nettype wire

// ### stpio_pkg.sv
// Constants for the status pin and pin configuration block
`default_nettype none
package stpio_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] STPIO_OFS_MISC   = 8'h00;
  localparam logic [7:0] STPIO_OFS_STCFG  = 8'h04;
  localparam logic [7:0] STPIO_OFS_PINSTS = 8'h08;
  localparam logic [7:0] STPIO_OFS_IRQSTS = 8'h0c;
  localparam logic [7:0] STPIO_OFS_IRQMSK = 8'h10;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  STPIO_MISC_RST  = 8'h2f;
  localparam logic [15:0] STPIO_STCFG_RST = 16'h0200;
  localparam logic [4:0]  STPIO_IRQ_RST   = 5'h00;
  // ==========================================================
  // Field positions of pin_misc_config
  localparam int STPIO_STARTUP_LSB = 6;
  localparam int STPIO_PPSTR_LSB   = 4;
  localparam int STPIO_ODSTR_LSB   = 2;
  localparam int STPIO_DATAPU_BIT  = 1;
  localparam int STPIO_CLKPU_BIT   = 0;
  // ==========================================================
  // Field positions of status_pin_config
  localparam int STPIO_OD_BIT  = 12;
  localparam int STPIO_HIZ_BIT = 11;
  localparam int STPIO_PD_BIT  = 10;
  localparam int STPIO_PU_BIT  = 9;
  localparam int STPIO_POL_BIT = 8;
  localparam int STPIO_SEL_LSB = 0;
  localparam logic [15:0] STPIO_STCFG_MASK = 16'h1f1f;
  // ==========================================================
  // Start-up gating modes
  localparam logic [1:0] STPIO_STARTUP_GATED = 2'h0;
  localparam logic [1:0] STPIO_STARTUP_FREE  = 2'h2;
  // ==========================================================
  // Status source select codes
  localparam logic [4:0] STPIO_SEL_PLL_LOCK  = 5'h00;
  localparam logic [4:0] STPIO_SEL_REF0_LOS  = 5'h02;
  localparam logic [4:0] STPIO_SEL_XTAL_LOS  = 5'h04;
  localparam logic [4:0] STPIO_SEL_REF0_ACT  = 5'h05;
  localparam logic [4:0] STPIO_SEL_REF0_INV  = 5'h07;
  localparam logic [4:0] STPIO_SEL_DEV_INT   = 5'h09;
  localparam logic [4:0] STPIO_SEL_DEV_READY = 5'h0a;
  localparam logic [4:0] STPIO_SEL_LOW       = 5'h1d;
  localparam logic [4:0] STPIO_SEL_HIGH      = 5'h1e;
  localparam logic [4:0] STPIO_SEL_NOPOL     = 5'h1f;
  localparam logic [4:0] STPIO_SEL_RB_MAX    = 5'h04;
  // ==========================================================
  // Interrupt status bits
  localparam int STPIO_IRQ_LOCK_UP   = 0;
  localparam int STPIO_IRQ_LOCK_DOWN = 1;
  localparam int STPIO_IRQ_REF0_LOS  = 2;
  localparam int STPIO_IRQ_XTAL_LOS  = 3;
  localparam int STPIO_IRQ_READY     = 4;
  localparam int STPIO_IRQ_W         = 5;
endpackage
`default_nettype wire

// ### stpio_tb_top.sv
// Self-checking bench for the status pin and pin configuration block
`default_nettype none
module stpio_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stpio_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [5:0]  ins = 6'h00;
  logic [31:0] rdat, q;
  logic        ack, clk_en, p_o, p_oe, p_pu, p_pd, d_pu, c_pu, irq, level, e;
  logic [1:0]  p_str, d_str;
  logic [4:0]  sels [9] = '{5'h00, 5'h02, 5'h04, 5'h05, 5'h07, 5'h0a, 5'h1d, 5'h1e, 5'h1f};
  int          n_fail = 0;
  int          n_compared = 0;

  always #2 clk = ~clk;

  stpio_top dut_u (
    .SYS_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PLL_LOCK(ins[0]), .REF0_SIGNAL_LOSS(ins[1]), .CRYSTAL_SIGNAL_LOSS(ins[2]),
    .REF0_ACTIVITY(ins[3]), .REF0_INVALID(ins[4]), .STARTUP_DONE(ins[5]),
    .CLK_OUT_EN(clk_en), .STATUS_PIN_O(p_o), .STATUS_PIN_OE(p_oe),
    .STATUS_PIN_PULLUP_EN(p_pu), .STATUS_PIN_PULLDOWN_EN(p_pd), .STATUS_PIN_STRENGTH(p_str),
    .DATA_PIN_STRENGTH(d_str), .DATA_PIN_PULLUP_EN(d_pu), .CLOCK_PIN_PULLUP_EN(c_pu),
    .IRQ(irq)
  );
  stpio_pin_mon mon_u (
    .clk(clk), .pin_o(p_o), .pin_oe(p_oe), .pin_pu(p_pu), .pin_pd(p_pd), .level(level)
  );
  // ==========================================================
  // Compare, verdict and bus tasks
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("[FAIL] bus ack expected 1 seen none");
    end
    q = rdat;
    cyc <= 1'b0;
    sel <= 4'h0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] ex);
    wb(1'b0, a, 32'h0);
    chk(what, ex, q);
  endtask
  task automatic pin_case(input logic [15:0] cfg, input logic [6:0] ex);
    wb(1'b1, STPIO_OFS_STCFG, {16'h0, cfg});
    ticks(3);
    chk("pin drive", {25'h0, ex}, {25'h0, p_oe, p_o, p_pu, p_pd, p_str, level});
  endtask
  // ==========================================================
  // Expected status pin value
  function automatic logic exp_pin(input logic [4:0] s, input logic p, input logic [5:0] v);
    logic b;
    case (s)
      STPIO_SEL_PLL_LOCK:  b = v[0];
      STPIO_SEL_REF0_LOS:  b = v[1];
      STPIO_SEL_XTAL_LOS:  b = v[2];
      STPIO_SEL_REF0_ACT:  b = v[3];
      STPIO_SEL_REF0_INV:  b = v[4];
      STPIO_SEL_DEV_READY: b = v[5];
      STPIO_SEL_HIGH:      b = 1'b1;
      STPIO_SEL_NOPOL:     return 1'b0;
      default:             b = 1'b0;
    endcase
    return b ^ p;
  endfunction
  // ==========================================================
  // Watchdog
  initial begin
    #40000;
    n_fail++;
    $display("[FAIL] run end expected reached seen watchdog");
    print_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h7288));
    ticks(4);
    rst <= 1'b0;
    rd_chk("misc reset", STPIO_OFS_MISC, 32'h2f);
    rd_chk("status cfg reset", STPIO_OFS_STCFG, 32'h200);
    chk("pull-ups", 32'h7, {29'h0, d_pu, c_pu, p_pu});
    chk("data strength", 32'h2, {30'h0, d_str});
    rd_chk("unmapped", 8'hfc, 32'h0);
    chk("outputs gated", 32'h0, 32'(clk_en));
    wb(1'b1, STPIO_OFS_MISC, 32'haf);
    ticks(3);
    chk("outputs free", 32'h1, 32'(clk_en));
    wb(1'b1, STPIO_OFS_MISC, 32'h2f);
    ticks(3);
    chk("outputs gated again", 32'h0, 32'(clk_en));
    @(posedge clk);
    ins <= 6'h01;
    ticks(3);
    chk("outputs after lock", 32'h1, 32'(clk_en));
    rd_chk("irq status", STPIO_OFS_IRQSTS, 32'h1);
    chk("irq disabled", 32'h0, 32'(irq));
    wb(1'b1, STPIO_OFS_IRQMSK, 32'h1);
    ticks(2);
    chk("irq enabled", 32'h1, 32'(irq));
    pin_case(16'h0209, 7'b1110101);
    wb(1'b1, STPIO_OFS_IRQSTS, 32'h1);
    ticks(3);
    chk("irq cleared", 32'h0, 32'(irq));
    chk("pin irq cleared", 32'h0, 32'(p_o));
    wb(1'b1, STPIO_OFS_IRQMSK, 32'h0);
    foreach (sels[i]) begin
      for (int r = 0; r < 4; r++) begin
        @(posedge clk);
        ins <= 6'($urandom());
        wb(1'b1, STPIO_OFS_STCFG, {23'h0, r[0], 3'h0, sels[i]});
        ticks(3);
        e = exp_pin(sels[i], r[0], ins);
        chk("pin value", 32'(e), 32'(p_o));
        chk("pin enable", 32'h1, 32'(p_oe));
        wb(1'b0, STPIO_OFS_PINSTS, 32'h0);
        chk("pin readback", (sels[i] <= STPIO_SEL_RB_MAX) ? 32'(e) : 32'h0, 32'(q[1]));
        chk("lock and clock status", 32'h5, {29'h0, q[2], 1'b0, q[0]});
      end
    end
    pin_case(16'h101d, 7'b1000110);
    pin_case(16'h121e, 7'b0010111);
    pin_case(16'h111e, 7'b1000110);
    pin_case(16'h0c1d, 7'b0001100);
    wb(1'b1, STPIO_OFS_MISC, 32'h10);
    ticks(3);
    chk("misc pins", 32'h14, {26'h0, d_str, p_str, d_pu, c_pu});
    rd_chk("misc readback", STPIO_OFS_MISC, 32'h10);
    pin_case(16'h101d, 7'b1000000);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### stpio_top.sv
// Pin configuration registers, start-up output gating and interrupts
// Notes on behaviour
// - Mode 0 keeps clock outputs off until PLL lock; mode 2 ignores lock.
// - Push-pull strength field, reset 2, sets status and data pin drive.
// - Open-drain strength field, reset 3, sets status pin pull-down strength.
// - Data pin pull-up bit, reset 1, enables its internal pull-up.
// - Clock pin pull-up bit, reset 1, enables its internal pull-up.
// - Open-drain pulls low for driven value 0, releases for 1.
// - Tristate bit, reset 0, floats the status pin.
// - Status pin pull-down bit enables pull-down; avoid with open-drain.
// - Status pin pull-up bit, reset 1; external pull-up advised for open-drain.
// - Polarity 0 drives the signal unchanged, 1 drives its inverse.
// - Polarity is ignored when the source select is 0x1F.
// - Select 0 PLL lock, 2 reference loss, 4 crystal loss.
// - Select 5 reference activity, 7 reference invalid.
// - Select 9 shows the device interrupt: status AND enable, reduced.
// - Select 0xA shows device ready after start-up completes.
// - Select 0x1D constant low, 0x1E constant high; others reserved.
// - Readback bit shows driven level for select 0 to 4, else 0.
//
// Added by the designer: the register offsets and register access over Wishbone.
`default_nettype none
module stpio_top
  import stpio_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        PLL_LOCK,
  input  wire logic        REF0_SIGNAL_LOSS,
  input  wire logic        CRYSTAL_SIGNAL_LOSS,
  input  wire logic        REF0_ACTIVITY,
  input  wire logic        REF0_INVALID,
  input  wire logic        STARTUP_DONE,
  output logic             CLK_OUT_EN,
  output logic             STATUS_PIN_O,
  output logic             STATUS_PIN_OE,
  output logic             STATUS_PIN_PULLUP_EN,
  output logic             STATUS_PIN_PULLDOWN_EN,
  output logic [1:0]       STATUS_PIN_STRENGTH,
  output logic [1:0]       DATA_PIN_STRENGTH,
  output logic             DATA_PIN_PULLUP_EN,
  output logic             CLOCK_PIN_PULLUP_EN,
  output logic             IRQ
);
  stpio_pin_if pif ();

  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0]  misc_ff;
  logic [15:0] stcfg_ff;
  logic [4:0]  irq_sts_ff;
  logic [4:0]  irq_msk_ff;
  logic        irq_ff;
  logic        lock_seen_ff;
  logic        clk_out_en_ff;
  logic        lock_prev_ff;
  logic        ref0_los_prev_ff;
  logic        xtal_los_prev_ff;
  logic        ready_prev_ff;
  logic        bus_req;
  logic        wr_go;
  logic [31:0] nxt_rdat;
  logic [4:0]  irq_ev;
  logic [4:0]  irq_clr;
  logic        nxt_clk_out_en;

  // ==========================================================
  // Bus slave: one wait state, write lands on the ack edge
  assign bus_req = WB_CYC_I && WB_STB_I;
  assign wr_go   = bus_req && WB_WE_I && ack_ff;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req && !ack_ff;
    end
  end

  always_comb begin
    nxt_rdat = 32'h0000_0000;
    unique case (WB_ADR_I)
      STPIO_OFS_MISC:   nxt_rdat = {24'h00_0000, misc_ff};
      STPIO_OFS_STCFG:  nxt_rdat = {16'h0000, stcfg_ff};
      STPIO_OFS_PINSTS: nxt_rdat = {29'h0, lock_seen_ff, pif.readback,
                                    clk_out_en_ff};
      STPIO_OFS_IRQSTS: nxt_rdat = {27'h0, irq_sts_ff};
      STPIO_OFS_IRQMSK: nxt_rdat = {27'h0, irq_msk_ff};
      default:          nxt_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdat_ff <= 32'h0000_0000;
    end else if (bus_req && !ack_ff && !WB_WE_I) begin
      rdat_ff <= nxt_rdat;
    end else begin
      rdat_ff <= 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;

  // ==========================================================
  // Configuration registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      misc_ff <= STPIO_MISC_RST;
    end else if (wr_go && WB_ADR_I == STPIO_OFS_MISC && WB_SEL_I[0]) begin
      misc_ff <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stcfg_ff <= STPIO_STCFG_RST;
    end else if (wr_go && WB_ADR_I == STPIO_OFS_STCFG) begin
      if (WB_SEL_I[0]) begin
        stcfg_ff[7:0] <= WB_DAT_I[7:0] & STPIO_STCFG_MASK[7:0];
      end
      if (WB_SEL_I[1]) begin
        stcfg_ff[15:8] <= WB_DAT_I[15:8] & STPIO_STCFG_MASK[15:8];
      end
    end
  end

  assign DATA_PIN_PULLUP_EN  = misc_ff[STPIO_DATAPU_BIT];
  assign CLOCK_PIN_PULLUP_EN = misc_ff[STPIO_CLKPU_BIT];
  assign DATA_PIN_STRENGTH   = misc_ff[STPIO_PPSTR_LSB +: 2];

  // ==========================================================
  // Start-up gating of the clock output drivers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_seen_ff <= 1'b0;
    end else if (PLL_LOCK) begin
      lock_seen_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_clk_out_en = lock_seen_ff || PLL_LOCK;
    if (misc_ff[STPIO_STARTUP_LSB +: 2] == STPIO_STARTUP_FREE) begin
      nxt_clk_out_en = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clk_out_en_ff <= 1'b0;
    end else begin
      clk_out_en_ff <= nxt_clk_out_en;
    end
  end

  assign CLK_OUT_EN = clk_out_en_ff;

  // ==========================================================
  // Interrupts: edge events, write one to clear, set wins
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_prev_ff     <= 1'b0;
      ref0_los_prev_ff <= 1'b0;
      xtal_los_prev_ff <= 1'b0;
      ready_prev_ff    <= 1'b0;
    end else begin
      lock_prev_ff     <= PLL_LOCK;
      ref0_los_prev_ff <= REF0_SIGNAL_LOSS;
      xtal_los_prev_ff <= CRYSTAL_SIGNAL_LOSS;
      ready_prev_ff    <= STARTUP_DONE;
    end
  end

  always_comb begin
    irq_ev = 5'h00;
    irq_ev[STPIO_IRQ_LOCK_UP]   = PLL_LOCK && !lock_prev_ff;
    irq_ev[STPIO_IRQ_LOCK_DOWN] = !PLL_LOCK && lock_prev_ff;
    irq_ev[STPIO_IRQ_REF0_LOS]  = REF0_SIGNAL_LOSS && !ref0_los_prev_ff;
    irq_ev[STPIO_IRQ_XTAL_LOS]  = CRYSTAL_SIGNAL_LOSS && !xtal_los_prev_ff;
    irq_ev[STPIO_IRQ_READY]     = STARTUP_DONE && !ready_prev_ff;
  end

  assign irq_clr = (wr_go && WB_ADR_I == STPIO_OFS_IRQSTS && WB_SEL_I[0]) ?
                   WB_DAT_I[4:0] : 5'h00;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_sts_ff <= STPIO_IRQ_RST;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_msk_ff <= STPIO_IRQ_RST;
    end else if (wr_go && WB_ADR_I == STPIO_OFS_IRQMSK && WB_SEL_I[0]) begin
      irq_msk_ff <= WB_DAT_I[4:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_sts_ff & irq_msk_ff);
    end
  end

  assign IRQ = irq_ff;

  // ==========================================================
  // Status pin driver
  assign pif.sel    = stcfg_ff[STPIO_SEL_LSB +: 5];
  assign pif.pol    = stcfg_ff[STPIO_POL_BIT];
  assign pif.od_en  = stcfg_ff[STPIO_OD_BIT];
  assign pif.hiz    = stcfg_ff[STPIO_HIZ_BIT];
  assign pif.pd_en  = stcfg_ff[STPIO_PD_BIT];
  assign pif.pu_en  = stcfg_ff[STPIO_PU_BIT];
  assign pif.pp_str = misc_ff[STPIO_PPSTR_LSB +: 2];
  assign pif.od_str = misc_ff[STPIO_ODSTR_LSB +: 2];
  assign pif.src    = {STARTUP_DONE, irq_ff, REF0_INVALID, REF0_ACTIVITY,
                       CRYSTAL_SIGNAL_LOSS, REF0_SIGNAL_LOSS, PLL_LOCK};

  stpio_pin_drv u_pin (
    .SYS_CLK (SYS_CLK),
    .SYS_RST (SYS_RST),
    .pif     (pif.pin)
  );

  assign STATUS_PIN_O           = pif.pin_o;
  assign STATUS_PIN_OE          = pif.pin_oe;
  assign STATUS_PIN_PULLUP_EN   = pif.pin_pu;
  assign STATUS_PIN_PULLDOWN_EN = pif.pin_pd;
  assign STATUS_PIN_STRENGTH    = pif.pin_str;

  // ==========================================================
  // Checks
  property p_ack_pulse;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_gated;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (misc_ff[7:6] == STPIO_STARTUP_GATED && !lock_seen_ff && !PLL_LOCK) |=> !CLK_OUT_EN;
  endproperty
  a_gated: assert property (p_gated) else $error("outputs enabled before lock");

  property p_free;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (misc_ff[7:6] == STPIO_STARTUP_FREE) |=> CLK_OUT_EN;
  endproperty
  a_free: assert property (p_free) else $error("outputs gated in free mode");

  property p_data_pu;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (wr_go && WB_ADR_I == STPIO_OFS_MISC && WB_SEL_I[0]) |=>
        (DATA_PIN_PULLUP_EN == $past(WB_DAT_I[1]) &&
         CLOCK_PIN_PULLUP_EN == $past(WB_DAT_I[0]));
  endproperty
  a_data_pu: assert property (p_data_pu) else $error("pull-up enables not updated");

  property p_str;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (!SYS_RST && !pif.od_en) |=> (STATUS_PIN_STRENGTH == $past(misc_ff[5:4]));
  endproperty
  a_str: assert property (p_str) else $error("push-pull strength wrong");

  property p_od_str;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (!SYS_RST && pif.od_en) |=> (STATUS_PIN_STRENGTH == $past(misc_ff[3:2]));
  endproperty
  a_od_str: assert property (p_od_str) else $error("open-drain strength wrong");

  property p_set_wins;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (irq_ev[STPIO_IRQ_LOCK_UP] && irq_clr[STPIO_IRQ_LOCK_UP]) |=>
        irq_sts_ff[STPIO_IRQ_LOCK_UP];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  property p_irq_out;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (|(irq_sts_ff & irq_msk_ff)) |=> IRQ;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

  property p_hiz_pin;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      pif.hiz |=> !STATUS_PIN_OE;
  endproperty
  a_hiz_pin: assert property (p_hiz_pin) else $error("status pin driven in tristate");

  property p_ack_answer;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (bus_req && !ack_ff) |=> WB_ACK_O;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  property p_rd_idle;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      !WB_ACK_O |-> (WB_DAT_O == 32'h0000_0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");

  property p_clear_bit;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (irq_clr[STPIO_IRQ_LOCK_UP] && !irq_ev[STPIO_IRQ_LOCK_UP]) |=>
        !irq_sts_ff[STPIO_IRQ_LOCK_UP];
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("status bit not cleared");

  property p_lock_sticky;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      lock_seen_ff |=> lock_seen_ff;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock record lost");

  property p_lock_opens;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      PLL_LOCK |=> CLK_OUT_EN;
  endproperty
  a_lock_opens: assert property (p_lock_opens) else $error("outputs gated after lock");

  property p_irq_low;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      !(|(irq_sts_ff & irq_msk_ff)) |=> !IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt raised without cause");

  property p_pd_follow;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      !SYS_RST |=> (STATUS_PIN_PULLDOWN_EN == $past(pif.pd_en));
  endproperty
  a_pd_follow: assert property (p_pd_follow) else $error("pull-down enable wrong");

  property p_pu_follow;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      !SYS_RST |=> (STATUS_PIN_PULLUP_EN == $past(pif.pu_en));
  endproperty
  a_pu_follow: assert property (p_pu_follow) else $error("pull-up enable wrong");
endmodule
`default_nettype wire
